// File: rtl/lki_pkg.sv
// Package with offsets, field positions, reset values and link encodings of the link initiator.
package lki_pkg;

  // Bus address layout: control registers, blocking window, non-blocking window.
  localparam int          ADDR_W        = 10;
  localparam logic [9:0]  OFS_CTL_PRI   = 10'h000;  // link_control_primary.
  localparam logic [9:0]  OFS_CTL_SEC   = 10'h001;  // link_control_secondary.
  localparam logic [9:0]  OFS_ERR_STAT  = 10'h002;  // link_error_status.
  localparam logic [9:0]  OFS_IRQ_STAT  = 10'h003;  // link_interrupt_busy_status.
  localparam logic [9:0]  OFS_ATTR_HI   = 10'h004;  // last_transaction_attr_addr_high.
  localparam logic [9:0]  OFS_ADDR_LO   = 10'h005;  // last_transaction_addr_low.
  localparam logic [9:0]  OFS_DATA_HI   = 10'h006;  // last_transaction_data_high.
  localparam logic [9:0]  OFS_DATA_LO   = 10'h007;  // last_transaction_data_low.
  localparam logic [1:0]  WIN_BLOCKING  = 2'h1;     // Address bits 9:8 of the blocking window.
  localparam logic [1:0]  WIN_NONBLOCK  = 2'h2;     // Address bits 9:8 of the non-blocking window.

  // Field positions in link_control_primary.
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_WIDTH     = 6;
  localparam int BIT_STOP_WAIT = 5;
  // Field positions in link_control_secondary.
  localparam int BIT_IRQ_EN    = 7;
  // Field positions in link_error_status.
  localparam int BIT_ERR_IF    = 7;
  localparam int BIT_ACK_ERR   = 6;
  localparam int BIT_CANCEL    = 5;
  localparam int BIT_TIMEOUT   = 4;
  // Field positions in link_interrupt_busy_status.
  localparam int BIT_TGT_IRQ   = 7;
  localparam int BIT_BUSY      = 6;
  // Field positions in last_transaction_attr_addr_high.
  localparam int BIT_READ      = 7;
  localparam int BIT_SIZE8     = 6;
  localparam int BIT_NONBLK    = 4;

  // Reset values.
  localparam logic [7:0]  RST_CTL_PRI   = 8'h00;
  localparam logic [7:0]  RST_CTL_SEC   = 8'h00;
  localparam logic [15:0] RST_DATA      = 16'h0000;

  // Command nibble sent first in every transaction; all-zero lines are the idle command.
  localparam logic [3:0]  CMD_ACTIVE    = 4'h8;  // Marks a real command.
  localparam logic [3:0]  CMD_READ      = 4'h4;  // Set for a read.
  localparam logic [3:0]  CMD_WORD      = 4'h2;  // Set for a 16-bit access.

  // Transaction shift register width.
  localparam int          SHIFT_W       = 40;

  // Transaction sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND,
    ST_RECV,
    ST_ACK
  } lki_state_t;

endpackage : lki_pkg

// File: rtl/lki_link_initiator.sv
// Die-to-die link initiator: registers, clock divider, transaction sequencer and pin control.
`timescale 1ns/1ns

module lki_link_initiator (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Operating mode of the controller.
  input  wire logic        stopMode,
  input  wire logic        waitMode,
  input  wire logic        specialMode,
  // Register and window port.
  input  wire logic [9:0]  busAddr,
  input  wire logic [15:0] busWdata,
  input  wire logic        busWord,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic      [15:0] busRdata,
  output logic             cpuHold,
  // Interface clock pin.
  output logic             linkClockOut,
  output logic             linkClockOutOe,
  // Lower data lines.
  input  wire logic [3:0]  linkDataLowerIn,
  output logic      [3:0]  linkDataLowerOut,
  output logic      [3:0]  linkDataLowerOe,
  output logic      [3:0]  linkDataLowerPd,
  // Upper data lines.
  input  wire logic [3:0]  linkDataUpperIn,
  output logic      [3:0]  linkDataUpperOut,
  output logic      [3:0]  linkDataUpperOe,
  output logic      [3:0]  linkDataUpperPd,
  // Target interrupt pin.
  input  wire logic        targetIrqIn,
  output logic             targetIrqPd,
  // Pin ownership and events.
  output logic             lowerPinsOwned,
  output logic             upperPinsOwned,
  output logic             linkErrIrq,
  output logic             targetIrqOut
);

  // Control fields.
  logic        enable_q;        // Link enable.
  logic        width8_q;        // Eight-line width.
  logic        stopWait_q;      // Stop the clock in WAIT.
  logic [1:0]  divider_q;       // Clock divider code.
  logic        irqEn_q;         // Target interrupt enable.
  logic [3:0]  timeout_q;       // Wait cycles allowed before acknowledge.
  logic        locked_q;        // Write-once fields locked.
  // Status fields.
  logic        errIf_q;
  logic        ackErr_q;
  logic        cancel_q;
  logic        timeErr_q;
  // Last transaction record.
  logic        lastRead_q;
  logic        lastByte_q;
  logic        lastNonBlk_q;
  logic [7:0]  lastAddr_q;
  logic [15:0] lastData_q;
  // Clock generation.
  logic [1:0]  phase_q;         // Position inside one interface clock period.
  logic        run_q;           // Divider running.
  logic        clkHigh_q;       // Divided clock level.
  logic        gateNeg_q;       // Gate for divide-by-one, changes while clk is low.
  // Sequencer.
  lki_pkg::lki_state_t state_q;
  logic [lki_pkg::SHIFT_W-1:0] shift_q;
  logic [2:0]  units_q;         // Units left in the current state.
  logic [3:0]  waits_q;         // Wait cycles seen in the acknowledge state.
  logic        drive_q;         // Initiator drives the data lines.
  logic [7:0]  dataOut_q;       // Registered data line level.

  // Address decode.
  wire logic       ctlSel     = (busAddr[9:3] == 7'h00);
  wire logic       winBlk     = (busAddr[9:8] == lki_pkg::WIN_BLOCKING);
  wire logic       winNonBlk  = (busAddr[9:8] == lki_pkg::WIN_NONBLOCK);
  wire logic       winSel     = winBlk | winNonBlk;
  wire logic       wrCtlPri   = busWr & (busAddr == lki_pkg::OFS_CTL_PRI);
  wire logic       wrCtlSec   = busWr & (busAddr == lki_pkg::OFS_CTL_SEC);
  wire logic       wrErrStat  = busWr & (busAddr == lki_pkg::OFS_ERR_STAT);
  wire logic       mayConfig  = ~locked_q | specialMode;

  // Halt request: STOP always, WAIT only with stop-in-wait set.
  wire logic       halt       = stopMode | (waitMode & stopWait_q);
  // Number of bus cycles per interface clock period minus one, and its high count.
  wire logic [1:0] lastPhase  = divider_q;
  wire logic [1:0] highCount  = 2'((3'(divider_q) + 3'h1) >> 1);
  wire logic       divOne     = (divider_q == 2'h0);
  // A link tick marks the bus cycle that ends a period; data change after it.
  wire logic       linkTick   = run_q & (phase_q == lastPhase);
  // A halt may stop the running divider only outside its high phase.
  wire logic       inHigh     = run_q & clkHigh_q & ~divOne;
  wire logic       runNext    = enable_q & (~halt | inHigh);

  // Bus request into a window.
  wire logic       winReq     = (busWr | busRd) & winSel & enable_q;
  wire logic       canStart   = (state_q == lki_pkg::ST_IDLE) & run_q & ~halt;
  wire logic       startTx    = winReq & canStart & ~errIf_q;
  wire logic       cancelTx   = winReq & canStart & errIf_q;

  // Data line view, upper half ignored in four-line width.
  wire logic [7:0] dataIn     = {linkDataUpperIn & {4{width8_q}}, linkDataLowerIn};
  wire logic [7:0] usedMask   = width8_q ? 8'hff : 8'h0f;
  wire logic       ackSeen    = ((dataIn & usedMask) == usedMask);
  wire logic       waitSeen   = ((dataIn & usedMask) == 8'h00);

  // Frame contents for a new transaction.
  wire logic [3:0] cmdNib     = lki_pkg::CMD_ACTIVE | (busRd ? lki_pkg::CMD_READ : 4'h0)
                                | (busWord ? lki_pkg::CMD_WORD : 4'h0);
  wire logic [15:0] txData    = busWord ? busWdata : {busWdata[7:0], 8'h00};
  // Both layouts fill the whole shift register; the unused tail is never put on the lines.
  wire logic [lki_pkg::SHIFT_W-1:0] frame = width8_q ?
                                {4'h0, cmdNib, busAddr[7:0], txData, 8'h00} :
                                {cmdNib, busAddr[7:0], txData, 12'h000};
  // Units to send: command, offset, and write data for writes.
  wire logic [2:0] sendUnits  = width8_q ?
                                (3'h2 + (busRd ? 3'h0 : (busWord ? 3'h2 : 3'h1))) :
                                (3'h3 + (busRd ? 3'h0 : (busWord ? 3'h4 : 3'h2)));
  wire logic [2:0] recvUnits  = width8_q ? (lastByte_q ? 3'h1 : 3'h2)
                                         : (lastByte_q ? 3'h2 : 3'h4);

  // Control registers; write-once fields take writes until the lock or in special mode, stop-in-wait and interrupt enable always.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q   <= lki_pkg::RST_CTL_PRI[lki_pkg::BIT_ENABLE];
      width8_q   <= lki_pkg::RST_CTL_PRI[lki_pkg::BIT_WIDTH];
      stopWait_q <= lki_pkg::RST_CTL_PRI[lki_pkg::BIT_STOP_WAIT];
      divider_q  <= lki_pkg::RST_CTL_PRI[1:0];
      irqEn_q    <= lki_pkg::RST_CTL_SEC[lki_pkg::BIT_IRQ_EN];
      timeout_q  <= lki_pkg::RST_CTL_SEC[3:0];
      locked_q   <= 1'b0;
    end else begin
      if (wrCtlPri) begin
        stopWait_q <= busWdata[lki_pkg::BIT_STOP_WAIT];
        if (mayConfig) begin
          enable_q  <= busWdata[lki_pkg::BIT_ENABLE];
          width8_q  <= busWdata[lki_pkg::BIT_WIDTH];
          divider_q <= busWdata[1:0];
        end
        // The lock arms only by a write of one to the enable in normal mode.
        if (mayConfig && !specialMode && busWdata[lki_pkg::BIT_ENABLE]) begin
          locked_q <= 1'b1;
        end
      end
      if (wrCtlSec) begin
        irqEn_q <= busWdata[lki_pkg::BIT_IRQ_EN];
        if (mayConfig) begin
          timeout_q <= busWdata[3:0];
        end
      end
    end
  end

  // Divider phase and level; the level is high for the first half, rounded down.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q     <= 1'b0;
      phase_q   <= 2'h0;
      clkHigh_q <= 1'b0;
    end else begin
      run_q <= runNext;
      if (!runNext) begin
        phase_q   <= 2'h0;
        clkHigh_q <= 1'b0;
      end else begin
        phase_q   <= (phase_q == lastPhase || !run_q) ? 2'h0 : 2'(phase_q + 2'h1);
        clkHigh_q <= (phase_q == lastPhase || !run_q) ? 1'b1
                     : (2'(phase_q + 2'h1) < highCount);
      end
    end
  end

  // Divide-by-one gate updates while clk is low, so the gated clock never glitches.
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gateNeg_q <= 1'b0;
    end else begin
      gateNeg_q <= run_q;
    end
  end

  // Interface clock: bus clock itself when divided by one, else the divided level.
  assign linkClockOut   = divOne ? (clk & gateNeg_q) : clkHigh_q;
  assign linkClockOutOe = enable_q;

  // Transaction sequencer; a halt abandons the transaction so lines return to idle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= lki_pkg::ST_IDLE;
      shift_q <= '0;
      units_q <= 3'h0;
      waits_q <= 4'h0;
    end else if (!enable_q || halt) begin
      state_q <= lki_pkg::ST_IDLE;
      units_q <= 3'h0;
      waits_q <= 4'h0;
    end else begin
      unique case (state_q)
        lki_pkg::ST_IDLE: begin
          if (startTx) begin
            state_q <= lki_pkg::ST_SEND;
            shift_q <= frame;
            units_q <= sendUnits;
          end
        end
        lki_pkg::ST_SEND: begin
          if (linkTick) begin
            shift_q <= width8_q ? {shift_q[lki_pkg::SHIFT_W-9:0], 8'h00}
                                : {shift_q[lki_pkg::SHIFT_W-5:0], 4'h0};
            units_q <= 3'(units_q - 3'h1);
            if (units_q == 3'h1) begin
              state_q <= lastRead_q ? lki_pkg::ST_RECV : lki_pkg::ST_ACK;
              units_q <= recvUnits;
              waits_q <= 4'h0;
            end
          end
        end
        lki_pkg::ST_RECV: begin
          if (linkTick) begin
            units_q <= 3'(units_q - 3'h1);
            if (units_q == 3'h1) begin
              state_q <= lki_pkg::ST_ACK;
            end
          end
        end
        lki_pkg::ST_ACK: begin
          if (linkTick) begin
            waits_q <= 4'(waits_q + 4'h1);
            if (ackSeen || !waitSeen || waits_q == timeout_q) begin
              state_q <= lki_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Initiator drives the lines except while the target answers.
  assign drive_q = ~((state_q == lki_pkg::ST_RECV) | (state_q == lki_pkg::ST_ACK));

  // Registered line level: frame units while sending, the idle command otherwise.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut_q <= 8'h00;
    end else if (state_q == lki_pkg::ST_SEND && !halt) begin
      dataOut_q <= width8_q ? shift_q[lki_pkg::SHIFT_W-1 -: 8]
                            : {4'h0, shift_q[lki_pkg::SHIFT_W-1 -: 4]};
    end else begin
      dataOut_q <= 8'h00;
    end
  end

  // Pin control: lower lines with the enable, upper only in eight-line width.
  assign lowerPinsOwned   = enable_q;
  assign upperPinsOwned   = enable_q & width8_q;
  assign linkDataLowerOut = dataOut_q[3:0];
  assign linkDataUpperOut = dataOut_q[7:4];
  assign linkDataLowerOe  = {4{lowerPinsOwned & (drive_q | halt)}};
  assign linkDataUpperOe  = {4{upperPinsOwned & (drive_q | halt)}};
  assign linkDataLowerPd  = {4{lowerPinsOwned & ~(drive_q | halt)}};
  assign linkDataUpperPd  = {4{upperPinsOwned & ~(drive_q | halt)}};
  assign targetIrqPd      = enable_q;

  // Status and record of the last transaction; a new error wins over a same-cycle clear.
  wire logic ackDone  = (state_q == lki_pkg::ST_ACK) & linkTick & enable_q & ~halt;
  wire logic ackBad   = ackDone & ~ackSeen & ~waitSeen;
  wire logic timeHit  = ackDone & waitSeen & (waits_q == timeout_q);
  wire logic newErr   = ackBad | timeHit | cancelTx;
  wire logic clrErr   = wrErrStat & busWdata[lki_pkg::BIT_ERR_IF];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      errIf_q   <= 1'b0;
      ackErr_q  <= 1'b0;
      cancel_q  <= 1'b0;
      timeErr_q <= 1'b0;
    end else begin
      errIf_q   <= newErr | (errIf_q & ~clrErr);
      ackErr_q  <= ackBad | (ackErr_q & ~clrErr);
      cancel_q  <= cancelTx | (cancel_q & ~clrErr);
      timeErr_q <= timeHit | (timeErr_q & ~clrErr);
    end
  end

  // Record of the last request and the data that came back.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastRead_q   <= 1'b0;
      lastByte_q   <= 1'b0;
      lastNonBlk_q <= 1'b0;
      lastAddr_q   <= 8'h00;
      lastData_q   <= lki_pkg::RST_DATA;
    end else if (startTx) begin
      lastRead_q   <= busRd;
      lastByte_q   <= ~busWord;
      lastNonBlk_q <= winNonBlk;
      lastAddr_q   <= busAddr[7:0];
      lastData_q   <= busRd ? lastData_q : (busWord ? busWdata : {8'h00, busWdata[7:0]});
    end else if (state_q == lki_pkg::ST_RECV && linkTick && enable_q && !halt) begin
      lastData_q   <= width8_q ? {lastData_q[7:0], dataIn}
                               : {lastData_q[11:0], dataIn[3:0]};
    end
  end

  // Blocking accesses hold the processor until the transaction ends.
  assign cpuHold      = (state_q != lki_pkg::ST_IDLE) & ~lastNonBlk_q;
  assign linkErrIrq   = errIf_q;
  assign targetIrqOut = targetIrqIn & irqEn_q & enable_q;

  // Read mux; window reads return the data held in the last transaction record.
  logic [7:0] regRead;
  always_comb begin
    regRead = 8'h00;
    unique case (busAddr[2:0])
      3'h0: regRead = {enable_q, width8_q, stopWait_q, 3'h0, divider_q};
      3'h1: regRead = {irqEn_q, 3'h0, timeout_q};
      3'h2: regRead = {errIf_q, ackErr_q, cancel_q, timeErr_q, 4'h0};
      3'h3: regRead = {targetIrqIn & enable_q, state_q != lki_pkg::ST_IDLE, 6'h00};
      3'h4: regRead = {lastRead_q, lastByte_q, 1'b0, lastNonBlk_q, 4'h0};
      3'h5: regRead = lastAddr_q;
      3'h6: regRead = lastData_q[15:8];
      3'h7: regRead = lastData_q[7:0];
    endcase
  end

  // Read data stand in the cycle after the strobe only; unmapped reads return zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= 16'h0000;
    end else if (busRd && ctlSel) begin
      busRdata <= {8'h00, regRead};
    end else if (busRd && winSel) begin
      busRdata <= lastData_q;
    end else begin
      busRdata <= 16'h0000;
    end
  end

endmodule : lki_link_initiator

// File: tb/lki_link_initiator_props.sv
// Checker of the link initiator pin behaviour, bound to its ports.
`timescale 1ns/1ns
module lki_link_checker (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       arst_n,
  // Operating modes.
  input wire logic       stopMode,
  input wire logic       waitMode,
  // Pins and ownership.
  input wire logic       linkClockOut,
  input wire logic       linkClockOutOe,
  input wire logic [3:0] linkDataLowerOut,
  input wire logic [3:0] linkDataLowerOe,
  input wire logic [3:0] linkDataLowerPd,
  input wire logic [3:0] linkDataUpperOe,
  input wire logic       lowerPinsOwned,
  input wire logic       upperPinsOwned
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A disabled link keeps its clock pin low.
  property p_clk_off;
    !linkClockOutOe && !$past(linkClockOutOe) |-> !linkClockOut;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock high while disabled");
  // A held stop leaves clock low once the high phase ends.
  property p_stop_clk;
    stopMode [*5] |-> !linkClockOut;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clock runs in stop");
  // A held stop drives the lower data lines low.
  property p_stop_data;
    stopMode [*5] |-> linkDataLowerOut == 4'h0;
  endproperty
  a_stop_data: assert property (p_stop_data) else $error("data not low in stop");
  // Upper lines stay released unless eight-line width is owned.
  property p_upper;
    !upperPinsOwned |-> linkDataUpperOe == 4'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper lines driven");
  // Every owned lower line that is an input has its pull-down on.
  property p_pull;
    lowerPinsOwned |-> linkDataLowerPd == ~linkDataLowerOe;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-down mismatch");
  // Ten pins imply the six base pins, which follow the enable.
  property p_own;
    (upperPinsOwned |-> lowerPinsOwned) and (lowerPinsOwned == linkClockOutOe);
  endproperty
  a_own: assert property (p_own) else $error("pin ownership mismatch");
  // The cycle after enabling, lines are driven as the idle command.
  property p_idle;
    $rose(linkClockOutOe) |-> ##1 linkDataLowerOut == 4'h0 && linkDataLowerOe == 4'hf;
  endproperty
  a_idle: assert property (p_idle) else $error("no idle after enable");
  // A running clock comes down again within a period unless STOP or WAIT mode is on.
  property p_toggle;
    $rose(linkClockOut) |-> ##[1:4] (!linkClockOut || stopMode || waitMode);
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock stuck high");
  // A two-cycle high phase is followed by at least as long a low phase.
  property p_duty;
    $rose(linkClockOut) ##1 linkClockOut |-> ##1 !linkClockOut ##1 !linkClockOut;
  endproperty
  a_duty: assert property (p_duty) else $error("high phase too long");
endmodule : lki_link_checker

bind lki_link_initiator lki_link_checker u_lki_link_checker (
  .clk(clk), .arst_n(arst_n), .stopMode(stopMode), .waitMode(waitMode),
  .linkClockOut(linkClockOut), .linkClockOutOe(linkClockOutOe),
  .linkDataLowerOut(linkDataLowerOut), .linkDataLowerOe(linkDataLowerOe),
  .linkDataLowerPd(linkDataLowerPd), .linkDataUpperOe(linkDataUpperOe),
  .lowerPinsOwned(lowerPinsOwned), .upperPinsOwned(upperPinsOwned)
);

// File: tb/lki_target_model.sv
// Behavioural target die on the far side of the link.
`timescale 1ns/1ns
module lki_target_model (
  // Link state seen from the target.
  input  wire logic       linkOn,
  input  wire logic [7:0] lineOe,
  // Interrupt request from the bench.
  input  wire logic       irqReq,
  // Levels put on the lines.
  output logic      [7:0] respVal,
  output logic            irqLevel
);
  // Released lines are answered high; while the link is off every line falls to the pull-down level.
  assign respVal = linkOn ? ~lineOe : 8'h00;
  // The interrupt is active high and only raised on a live link.
  assign irqLevel = irqReq & linkOn;
endmodule : lki_target_model

// File: tb/lki_link_initiator_test.sv
// Self-checking testbench of the link initiator.
`timescale 1ns/1ns
module lki_link_initiator_test;
  logic        clk, arst_n, stopMode, waitMode, specialMode, busWord, busWr, busRd;
  logic        cpuHold, clkOut, clkOe, lowOwn, upOwn, irqPd, irqLvl, irqReq, rdLate;
  logic        irqOut, errOut;
  logic [9:0]  busAddr;
  logic [15:0] busWdata, busRdata, d;
  logic [3:0]  loOut, loOe, loPd, upOut, upOe, upPd, loIn, upIn;
  logic [7:0]  resp;
  logic [15:0] expQ[$];
  int          bad_count, compares, seed;
  // Each line is the driven value or the target's level.
  assign loIn = (loOe & loOut) | (~loOe & resp[3:0]);
  assign upIn = (upOe & upOut) | (~upOe & resp[7:4]);
  lki_link_initiator u_lki_link_initiator (.clk(clk), .arst_n(arst_n), .stopMode(stopMode),
    .waitMode(waitMode), .specialMode(specialMode), .busAddr(busAddr), .busWdata(busWdata),
    .busWord(busWord), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .cpuHold(cpuHold),
    .linkClockOut(clkOut), .linkClockOutOe(clkOe), .linkDataLowerIn(loIn),
    .linkDataLowerOut(loOut), .linkDataLowerOe(loOe), .linkDataLowerPd(loPd),
    .linkDataUpperIn(upIn), .linkDataUpperOut(upOut), .linkDataUpperOe(upOe),
    .linkDataUpperPd(upPd), .targetIrqIn(irqLvl), .targetIrqPd(irqPd),
    .lowerPinsOwned(lowOwn), .upperPinsOwned(upOwn), .linkErrIrq(errOut),
    .targetIrqOut(irqOut));
  lki_target_model u_lki_target_model (.linkOn(clkOe), .lineOe({upOe, loOe}),
    .irqReq(irqReq), .respVal(resp), .irqLevel(irqLvl));
  // Bus clock of 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compares one value and counts it.
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // One write cycle; strobes stay up so back-to-back cycles need no gap.
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    busAddr <= a;
    busWdata <= v;
    busRd <= 1'b0;
    busWr <= 1'b1;
    @(posedge clk);
  endtask : wr
  // One read cycle; the expected value is queued for the monitor.
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    busAddr <= a;
    busWr <= 1'b0;
    busRd <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
  endtask : rd
  // Drops both strobes and lets cycles pass.
  task automatic idle(input int n);
    busWr <= 1'b0;
    busRd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Read data stand only in the cycle after the strobe; settled by the falling edge.
  always @(posedge clk) rdLate <= busRd;
  always @(negedge clk) if (rdLate === 1'b1) cmp("busRdata", expQ.pop_front(), busRdata);
  // Watchdog against a hang.
  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    {stopMode, waitMode, specialMode, busWord, busWr, busRd, irqReq} = 7'h00;
    busAddr = 10'h000;
    busWdata = 16'h0000;
    seed = 8;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(10'h000, 16'h0000);
    rd(10'h010, 16'h0000);
    wr(10'h000, 16'h00c1);
    rd(10'h000, 16'h00c1);
    wr(10'h000, 16'h0022);
    rd(10'h000, 16'h00e1);
    d = 16'($random(seed));
    busWord <= 1'b1;
    wr(10'h105, d);
    idle(2);
    for (int i = 0; i < 300 && cpuHold !== 1'b0; i++) @(posedge clk);
    rd(10'h005, 16'h0005);
    rd(10'h006, {8'h00, d[15:8]});
    rd(10'h007, {8'h00, d[7:0]});
    wr(10'h001, 16'h0080);
    irqReq <= 1'b1;
    idle(2);
    rd(10'h003, 16'h0080);
    idle(1);
    cmp("targetIrqOut", 16'h0001, {15'h0000, irqOut});
    cmp("linkErrIrq", 16'h0000, {15'h0000, errOut});
    stopMode <= 1'b1;
    idle(10);
    stopMode <= 1'b0;
    waitMode <= 1'b1;
    idle(10);
    waitMode <= 1'b0;
    specialMode <= 1'b1;
    idle(6);
    wr(10'h000, 16'h0000);
    rd(10'h000, 16'h0000);
    idle(2);
    cmp("lowerPinsOwned", 16'h0000, {15'h0000, lowOwn});
    for (int c = 0; c < 4; c++) begin
      wr(10'h000, 16'h0080 | 16'(c));
      idle(12);
    end
    // Non-blocking word read: the window returns the previous record, the target answers ones.
    rd(10'h205, d);
    idle(60);
    rd(10'h006, 16'h00ff);
    rd(10'h007, 16'h00ff);
    rd(10'h004, 16'h0090);
    idle(2);
    cmp("upperPinsOwned", 16'h0000, {15'h0000, upOwn});
    cmp("lowerPinsOwned", 16'h0001, {15'h0000, lowOwn});
    print_verdict();
  end
endmodule : lki_link_initiator_test
